// ### rtl/calarm_top.sv
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// - Minute alarm: disable bit7, BCD minute
// - Hour alarm: disable bit7, 12/24 hour fields
// - Hour format chosen by config bit
// - Day alarm: disable bit7, BCD day
// - Weekday alarm: disable bit7, weekday 0-6
// - Enabled valid fields compared with time
// - Disabled fields ignored in comparison
// - Flag set when all enabled first match
// - Flag sticky; re-set only on new increment
// - Interrupt output follows flag when enabled
// - Clear releases interrupt; level only
// - Flag writes AND with written data
// - Alarm flag at bit 3, others 7..4
module calarm_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic time_tick,
    input wire logic [7:0] cur_minute,
    input wire logic [7:0] cur_hour,
    input wire logic [7:0] cur_day,
    input wire logic [2:0] cur_weekday,
    input wire logic [3:0] timer_flag_set,
    output logic irq_out_n,
    output logic irq_out_oe,
    output logic irq
);
    typedef enum logic [2:0] {
        CALARM_W_IDLE = 3'h1,
        CALARM_W_DO = 3'h2,
        CALARM_W_RESP = 3'h4
    } calarm_wstate_t;

    calarm_wstate_t wst_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_have_r;
    logic w_have_r;
    logic [7:0] alarm_min_r;
    logic [7:0] alarm_hour_r;
    logic [7:0] alarm_day_r;
    logic [7:0] alarm_wday_r;
    logic [7:0] flag_ctrl_r;
    logic [1:0] config_r;
    logic [4:0] irq_status_r;
    logic [4:0] irq_mask_r;
    logic tick_s1_r;
    logic tick_s2_r;
    logic tick_s3_r;
    logic [7:0] min_s1_r;
    logic [7:0] min_s2_r;
    logic [7:0] hour_s1_r;
    logic [7:0] hour_s2_r;
    logic [7:0] day_s1_r;
    logic [7:0] day_s2_r;
    logic [2:0] wday_s1_r;
    logic [2:0] wday_s2_r;
    logic [3:0] tflag_s1_r;
    logic [3:0] tflag_s2_r;
    logic match_prev_r;
    logic match_now;
    logic advance;
    logic alarm_event;
    logic wr_do;
    logic wr_flag;
    logic wr_status;
    logic [7:0] wbyte;

    function automatic logic field_hit(input logic [7:0] alarm,
                                       input logic [7:0] cur,
                                       input logic [7:0] mask);
        // Disabled field passes, so it neither blocks nor matches alone
        // field compare
        field_hit = alarm[calarm_pkg::DISABLE_BIT] ||
                    ((alarm & mask) == (cur & mask));
    endfunction

    function automatic logic any_enabled(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic [7:0] c,
                                         input logic [7:0] d);
        any_enabled = !(a[7] && b[7] && c[7] && d[7]);
    endfunction

    // Time inputs come from the counter domain; resync before use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_s1_r <= 1'b0;
            tick_s2_r <= 1'b0;
            tick_s3_r <= 1'b0;
            min_s1_r <= 8'h00;
            min_s2_r <= 8'h00;
            hour_s1_r <= 8'h00;
            hour_s2_r <= 8'h00;
            day_s1_r <= 8'h00;
            day_s2_r <= 8'h00;
            wday_s1_r <= 3'h0;
            wday_s2_r <= 3'h0;
            tflag_s1_r <= 4'h0;
            tflag_s2_r <= 4'h0;
        end else begin
            tick_s1_r <= time_tick;
            tick_s2_r <= tick_s1_r;
            tick_s3_r <= tick_s2_r;
            min_s1_r <= cur_minute;
            min_s2_r <= min_s1_r;
            hour_s1_r <= cur_hour;
            hour_s2_r <= hour_s1_r;
            day_s1_r <= cur_day;
            day_s2_r <= day_s1_r;
            wday_s1_r <= cur_weekday;
            wday_s2_r <= wday_s1_r;
            tflag_s1_r <= timer_flag_set;
            tflag_s2_r <= tflag_s1_r;
        end
    end

    assign advance = tick_s2_r && !tick_s3_r;

    always_comb begin
        logic [7:0] hmask;
        hmask = config_r[calarm_pkg::CFG_12H_BIT] ?
                calarm_pkg::HOUR12_MASK | 8'h20 :
                calarm_pkg::HOUR24_MASK;
        match_now = any_enabled(alarm_min_r, alarm_hour_r, alarm_day_r,
                                alarm_wday_r) &&
            field_hit(alarm_min_r, min_s2_r, calarm_pkg::MIN_MASK) &&
            field_hit(alarm_hour_r, hour_s2_r, hmask) &&
            field_hit(alarm_day_r, day_s2_r, calarm_pkg::DAY_MASK) &&
            field_hit(alarm_wday_r, {5'h00, wday_s2_r},
                      calarm_pkg::WDAY_MASK);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_prev_r <= 1'b0;
        end else if (advance) begin
            match_prev_r <= match_now;
        end
    end

    assign alarm_event = advance && match_now && !match_prev_r;

    // AXI write channel: accept address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_r <= CALARM_W_IDLE;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= calarm_pkg::RESP_OKAY;
        end else begin
            unique case (wst_r)
                CALARM_W_IDLE: begin
                    if (s_axi_awvalid && !aw_have_r) begin
                        aw_have_r <= 1'b1;
                        awaddr_r <= s_axi_awaddr[7:0];
                    end
                    if (s_axi_wvalid && !w_have_r) begin
                        w_have_r <= 1'b1;
                        wdata_r <= s_axi_wdata;
                        wstrb_r <= s_axi_wstrb;
                    end
                    if ((aw_have_r || s_axi_awvalid) &&
                        (w_have_r || s_axi_wvalid)) begin
                        wst_r <= CALARM_W_DO;
                    end
                end
                CALARM_W_DO: begin
                    aw_have_r <= 1'b0;
                    w_have_r <= 1'b0;
                    s_axi_bvalid <= 1'b1;
                    s_axi_bresp <= wr_ok(awaddr_r) ? calarm_pkg::RESP_OKAY
                                                   : calarm_pkg::RESP_SLVERR;
                    wst_r <= CALARM_W_RESP;
                end
                CALARM_W_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wst_r <= CALARM_W_IDLE;
                    end
                end
            endcase
        end
    end

    function automatic logic wr_ok(input logic [7:0] a);
        wr_ok = a == calarm_pkg::ADDR_MIN_ALARM ||
                a == calarm_pkg::ADDR_HOUR_ALARM ||
                a == calarm_pkg::ADDR_DAY_ALARM ||
                a == calarm_pkg::ADDR_WDAY_ALARM ||
                a == calarm_pkg::ADDR_FLAG_CTRL ||
                a == calarm_pkg::ADDR_CONFIG ||
                a == calarm_pkg::ADDR_IRQ_STATUS ||
                a == calarm_pkg::ADDR_IRQ_MASK;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= wst_r == CALARM_W_IDLE && s_axi_awvalid &&
                             !aw_have_r && !s_axi_awready;
            s_axi_wready <= wst_r == CALARM_W_IDLE && s_axi_wvalid &&
                            !w_have_r && !s_axi_wready;
        end
    end

    assign wr_do = wst_r == CALARM_W_DO && wstrb_r[0];
    assign wbyte = wdata_r[7:0];
    assign wr_flag = wr_do && awaddr_r == calarm_pkg::ADDR_FLAG_CTRL;
    assign wr_status = wr_do && awaddr_r == calarm_pkg::ADDR_IRQ_STATUS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_min_r <= calarm_pkg::ALARM_RESET;
            alarm_hour_r <= calarm_pkg::ALARM_RESET;
            alarm_day_r <= calarm_pkg::ALARM_RESET;
            alarm_wday_r <= calarm_pkg::ALARM_RESET;
            config_r <= calarm_pkg::CONFIG_RESET;
            irq_mask_r <= calarm_pkg::IRQ_MASK_RESET;
        end else if (wr_do) begin
            unique case (awaddr_r)
                calarm_pkg::ADDR_MIN_ALARM: alarm_min_r <= wbyte;
                calarm_pkg::ADDR_HOUR_ALARM: alarm_hour_r <= wbyte & 8'hbf;
                calarm_pkg::ADDR_DAY_ALARM: alarm_day_r <= wbyte & 8'hbf;
                calarm_pkg::ADDR_WDAY_ALARM: alarm_wday_r <= wbyte & 8'h87;
                calarm_pkg::ADDR_CONFIG: config_r <= wbyte[1:0];
                calarm_pkg::ADDR_IRQ_MASK: irq_mask_r <= wbyte[4:0];
                default: ;
            endcase
        end
    end

    // Flags 7..3; set wins over an AND-clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_ctrl_r <= calarm_pkg::FLAG_RESET;
        end else begin
            flag_ctrl_r[7:3] <= (wr_flag ? flag_ctrl_r[7:3] & wbyte[7:3]
                                         : flag_ctrl_r[7:3]) |
                                {tflag_s2_r, alarm_event};
            flag_ctrl_r[2:0] <= 3'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_r <= 5'h00;
        end else begin
            irq_status_r <= (wr_status ? irq_status_r & ~wbyte[4:0]
                                       : irq_status_r) |
                            {tflag_s2_r, alarm_event};
        end
    end

    // level interrupt pin follows the flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_out_n <= 1'b1;
            irq_out_oe <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq_out_n <= 1'b0;
            irq_out_oe <= config_r[calarm_pkg::CFG_IRQ_EN_BIT] &&
                          flag_ctrl_r[calarm_pkg::ALARM_FLAG_BIT] &&
                          !(wr_flag && !wbyte[calarm_pkg::ALARM_FLAG_BIT]
                            && !alarm_event);
            irq <= |(irq_status_r & irq_mask_r);
        end
    end

    // Read channel, one cycle latency
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= calarm_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (s_axi_arvalid && !s_axi_rvalid &&
                         !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= calarm_pkg::RESP_OKAY;
                unique case (s_axi_araddr[7:0])
                    calarm_pkg::ADDR_MIN_ALARM:
                        s_axi_rdata <= {24'h0, alarm_min_r};
                    calarm_pkg::ADDR_HOUR_ALARM:
                        s_axi_rdata <= {24'h0, alarm_hour_r};
                    calarm_pkg::ADDR_DAY_ALARM:
                        s_axi_rdata <= {24'h0, alarm_day_r};
                    calarm_pkg::ADDR_WDAY_ALARM:
                        s_axi_rdata <= {24'h0, alarm_wday_r};
                    calarm_pkg::ADDR_FLAG_CTRL:
                        s_axi_rdata <= {24'h0, flag_ctrl_r};
                    calarm_pkg::ADDR_CONFIG:
                        s_axi_rdata <= {30'h0, config_r};
                    calarm_pkg::ADDR_TIME:
                        s_axi_rdata <= {5'h00, wday_s2_r, day_s2_r,
                                        hour_s2_r, min_s2_r};
                    calarm_pkg::ADDR_IRQ_STATUS:
                        s_axi_rdata <= {27'h0, irq_status_r};
                    calarm_pkg::ADDR_IRQ_MASK:
                        s_axi_rdata <= {27'h0, irq_mask_r};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= calarm_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end
    end
endmodule

// ### pkg/calarm_pkg.sv
package calarm_pkg;
    // Byte addresses of the AXI4-Lite register map
    localparam logic [7:0] ADDR_MIN_ALARM = 8'h28; // index 0x0a
    localparam logic [7:0] ADDR_HOUR_ALARM = 8'h2c; // index 0x0b
    localparam logic [7:0] ADDR_DAY_ALARM = 8'h30; // index 0x0c
    localparam logic [7:0] ADDR_WDAY_ALARM = 8'h34; // index 0x0d
    localparam logic [7:0] ADDR_FLAG_CTRL = 8'h40;
    localparam logic [7:0] ADDR_CONFIG = 8'h44;
    localparam logic [7:0] ADDR_TIME = 8'h48;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h4c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h50;
    // Printed register indices
    localparam logic [7:0] IDX_MIN_ALARM = 8'h0a;
    localparam logic [7:0] IDX_HOUR_ALARM = 8'h0b;
    localparam logic [7:0] IDX_DAY_ALARM = 8'h0c;
    localparam logic [7:0] IDX_WDAY_ALARM = 8'h0d;
    // Field positions
    localparam int DISABLE_BIT = 7;
    localparam int AFTERNOON_BIT = 5;
    localparam int ALARM_FLAG_BIT = 3;
    localparam int CFG_IRQ_EN_BIT = 0;
    localparam int CFG_12H_BIT = 1;
    // Reset values
    localparam logic [7:0] ALARM_RESET = 8'h80;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [1:0] CONFIG_RESET = 2'h0;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
    // Field masks of the alarm registers
    localparam logic [7:0] MIN_MASK = 8'h7f;
    localparam logic [7:0] HOUR24_MASK = 8'h3f;
    localparam logic [7:0] HOUR12_MASK = 8'h1f;
    localparam logic [7:0] DAY_MASK = 8'h3f;
    localparam logic [7:0] WDAY_MASK = 8'h07;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### test/calarm_top_assertions.sv
`timescale 1ns/1ps
module calarm_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic time_tick,
    input wire logic irq_out_n,
    input wire logic irq_out_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_pin_low_only: assert property ($past(aresetn) |-> !irq_out_n)
        else $error("interrupt pin data not low");
    a_oe_after_tick: assert property ($rose(irq_out_oe) |->
        $past(time_tick, 4) || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("interrupt rose without time advance or write");
    a_oe_drop_write: assert property ($fell(irq_out_oe) |->
        s_axi_bvalid || $past(s_axi_bvalid))
        else $error("interrupt released without a write");
    a_write_answer: assert property (s_axi_awready && s_axi_wready
        |-> ##[0:2] s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid
        |-> ##1 s_axi_rvalid)
        else $error("read data missing");
    a_aw_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    a_b_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_data_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    c_irq_rise: cover property ($rose(irq_out_oe));
    c_irq_fall: cover property ($fell(irq_out_oe));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind calarm_top calarm_checker u_chk (.aclk, .aresetn, .s_axi_awready,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .time_tick, .irq_out_n, .irq_out_oe);

// ### test/calarm_time_src.sv
`timescale 1ns/1ps
module calarm_time_src (
    input wire logic aclk,
    output logic time_tick,
    output logic [7:0] cur_minute,
    output logic [7:0] cur_hour,
    output logic [7:0] cur_day,
    output logic [2:0] cur_weekday
);
    initial begin
        time_tick = 1'b0;
        cur_minute = 8'h00;
        cur_hour = 8'h00;
        cur_day = 8'h01;
        cur_weekday = 3'h0;
    end
    // Counters settle well before the tick and stay put past the sync chain
    task automatic advance(input logic [26:0] t);
        @(posedge aclk);
        {cur_weekday, cur_day, cur_hour, cur_minute} <= t;
        repeat (4) @(posedge aclk);
        time_tick <= 1'b1;
        repeat (8) @(posedge aclk);
        time_tick <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask
endmodule

// ### test/calarm_top_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module calarm_top_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, tick;
    logic [1:0] bresp, rresp;
    logic [3:0] tset = 4'h0;
    logic [3:0] wstrb = 4'hf;
    logic [7:0] mn, hr, dy;
    logic [2:0] wd;
    logic irq_out_n, irq_out_oe, irq;
    int n_errors = 0;
    int checks = 0;
    logic [7:0] adr [4] = '{calarm_pkg::ADDR_MIN_ALARM,
        calarm_pkg::ADDR_HOUR_ALARM, calarm_pkg::ADDR_DAY_ALARM,
        calarm_pkg::ADDR_WDAY_ALARM};
    logic [7:0] msk [4] = '{8'hff, 8'hbf, 8'hbf, 8'h87};
    logic [7:0] fc = calarm_pkg::ADDR_FLAG_CTRL;
    always #20 aclk = ~aclk;
    calarm_time_src tsrc (.aclk(aclk), .time_tick(tick), .cur_minute(mn),
        .cur_hour(hr), .cur_day(dy), .cur_weekday(wd));
    calarm_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .time_tick(tick), .cur_minute(mn),
        .cur_hour(hr), .cur_day(dy), .cur_weekday(wd),
        .timer_flag_set(tset), .irq_out_n(irq_out_n),
        .irq_out_oe(irq_out_oe), .irq(irq));
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Response ready goes up with the request, so the answer is taken
    // at the first edge that shows it
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr <= {24'h0, a};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
        if (n == 40) begin
            n_errors++;
            conclude();
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
        if (n == 40) begin
            n_errors++;
            conclude();
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic [1:0] r;
        rd(a, d, r);
        `CHK($sformatf("reg %h", a), e, d)
    endtask
    task automatic wchk(input logic [7:0] a, input logic [7:0] d,
                        input logic [1:0] e);
        logic [1:0] r;
        wr(a, d, r);
        `CHK($sformatf("resp %h", a), e, r)
    endtask
    // Alarm words are {weekday, day, hour, minute}; e is {pin, flag}
    task automatic try(input logic [31:0] al, input logic [7:0] cfg,
                       input logic [26:0] t, input logic [1:0] e);
        for (int i = 0; i < 4; i++) begin
            wchk(adr[i], al[8*i+:8], calarm_pkg::RESP_OKAY);
        end
        wchk(calarm_pkg::ADDR_CONFIG, cfg, calarm_pkg::RESP_OKAY);
        tsrc.advance({3'h3, 8'h28, 8'h11, 8'h58});
        wchk(fc, 8'hf0, calarm_pkg::RESP_OKAY);
        tsrc.advance(t);
        rchk(fc, {4'h0, e[0], 3'h0});
        `CHK("irq_out_oe", e[1], irq_out_oe)
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    initial begin
        logic [7:0] d;
        logic [1:0] r;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) rchk(adr[i], 8'h80);
        rchk(fc, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wchk(adr[i], 8'hff, calarm_pkg::RESP_OKAY);
            rchk(adr[i], msk[i]);
        end
        // Byte lane 0 off: accepted but the register keeps its value
        wstrb <= 4'h0;
        wchk(adr[0], 8'h12, calarm_pkg::RESP_OKAY);
        wstrb <= 4'hf;
        rchk(adr[0], 8'hff);
        wchk(8'h04, 8'h00, calarm_pkg::RESP_SLVERR);
        wchk(calarm_pkg::ADDR_TIME, 8'h00, calarm_pkg::RESP_SLVERR);
        rd(8'h08, d, r);
        `CHK("unmapped resp", calarm_pkg::RESP_SLVERR, r)
        done("registers");
        try(32'h80808030, 8'h01, {3'h2, 8'h15, 8'h09, 8'h30}, 2'h3);
        try(32'h80800530, 8'h01, {3'h2, 8'h15, 8'h06, 8'h30}, 2'h0);
        try(32'h80802580, 8'h03, {3'h2, 8'h15, 8'h25, 8'h30}, 2'h3);
        try(32'h80802580, 8'h03, {3'h2, 8'h15, 8'h05, 8'h30}, 2'h0);
        try(32'h06318080, 8'h00, {3'h6, 8'h31, 8'h09, 8'h30}, 2'h1);
        try(32'h80808080, 8'h01, {3'h6, 8'h31, 8'h09, 8'h30}, 2'h0);
        done("compare");
        try(32'h06318080, 8'h00, {3'h6, 8'h31, 8'h09, 8'h30}, 2'h1);
        wchk(fc, 8'hf0, calarm_pkg::RESP_OKAY);
        tsrc.advance({3'h6, 8'h31, 8'h09, 8'h30});
        rchk(fc, 8'h00);
        tsrc.advance({3'h6, 8'h30, 8'h09, 8'h30});
        tsrc.advance({3'h6, 8'h31, 8'h09, 8'h30});
        rchk(fc, 8'h08);
        wchk(calarm_pkg::ADDR_CONFIG, 8'h01, calarm_pkg::RESP_OKAY);
        rchk(fc, 8'h08);
        `CHK("irq_out_oe", 1'b1, irq_out_oe)
        wchk(fc, 8'hf0, calarm_pkg::RESP_OKAY);
        `CHK("irq_out_oe", 1'b0, irq_out_oe)
        `CHK("irq_out_n", 1'b0, irq_out_n)
        done("sticky");
        tset <= 4'hf;
        repeat (4) @(posedge aclk);
        tset <= 4'h0;
        repeat (6) @(posedge aclk);
        rchk(fc, 8'hf0);
        wchk(fc, 8'h70, calarm_pkg::RESP_OKAY);
        rchk(fc, 8'h70);
        rchk(calarm_pkg::ADDR_IRQ_STATUS, 8'h1f);
        `CHK("irq masked", 1'b0, irq)
        wchk(calarm_pkg::ADDR_IRQ_MASK, 8'h1f, calarm_pkg::RESP_OKAY);
        rchk(calarm_pkg::ADDR_IRQ_MASK, 8'h1f);
        `CHK("irq", 1'b1, irq)
        wchk(calarm_pkg::ADDR_IRQ_STATUS, 8'h1f, calarm_pkg::RESP_OKAY);
        rchk(calarm_pkg::ADDR_IRQ_STATUS, 8'h00);
        `CHK("irq cleared", 1'b0, irq)
        done("flags");
        conclude();
    end
endmodule
